/* File: sim/ics_field_dev.sv */
`timescale 1ns/1ns
`default_nettype none
// Field device driving the isolated source pins; lines idle low
module ics_field_dev (
   input wire logic i_clock,
   output logic o_function_pin,
   output logic o_zero_src_pin
);
   // --------
   // Pin drive
   // --------
   // Both pins start released, which reads as low
   initial begin
      o_function_pin = 1'b0;
      o_zero_src_pin = 1'b0;
   end

   // Sets one pin after a clock edge
   task automatic put(input logic sel, input logic lvl);
      if (sel) begin
         o_zero_src_pin <= lvl;
      end else begin
         o_function_pin <= lvl;
      end
   endtask

   // Pulse train keeping least high width and least period
   task automatic pulses(input logic sel, input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge i_clock);
         put(sel, 1'b1);
         repeat (ics_pkg::SRC_PW_CYCLES) @(posedge i_clock);
         put(sel, 1'b0);
         repeat (ics_pkg::SRC_PER_CYCLES - ics_pkg::SRC_PW_CYCLES) begin
            @(posedge i_clock);
         end
      end
   endtask
endmodule
`default_nettype wire

/* File: sim/isolated_counter_source_path_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module isolated_counter_source_path_tb;
   // --------
   // Settings
   // --------
   localparam int OFF = 20;
   localparam logic [31:0] EN = 32'h1 << ics_pkg::CTRL_ENABLE;
   localparam logic [31:0] FALL = 32'h1 << ics_pkg::CTRL_FALL;
   localparam logic [31:0] DOWN = 32'h1 << ics_pkg::CTRL_DOWN;
   localparam logic [31:0] EXP = 32'h1 << ics_pkg::CTRL_EXPORT;
   localparam logic [31:0] GLV = 32'h1 << ics_pkg::CTRL_GATE_LEVEL;
   localparam logic [31:0] GEN = 32'h1 << ics_pkg::CTRL_GATE_EN;
   localparam logic [31:0] IDLE = 32'h1 << ics_pkg::CTRL_IDLE_HIGH;
   localparam logic [31:0] TGL = 32'h1 << ics_pkg::CTRL_OUT_TOGGLE;
   logic clock, reset, wr, rd, gate, aux, asel, oc;
   logic fpin, zpin, sp_out, sp_oe, cout, tc;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, v;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   int m;

   // Design and field device
   ics_counter #(.WIDTH(32), .FAULT_OFF(OFF)) i_dut (
      .i_clock(clock), .i_reset(reset), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_programmable_function_pin(fpin), .i_counter_zero_source_pin(zpin),
      .i_counter_gate_input(gate), .i_aux_input(aux),
      .i_aux_select(asel), .i_overcurrent(oc),
      .o_source_pin_out(sp_out), .o_source_pin_oe(sp_oe),
      .o_counter_out(cout), .o_terminal_count(tc));
   ics_field_dev i_fld (
      .i_clock(clock), .o_function_pin(fpin), .o_zero_src_pin(zpin));

   // 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Hang guard
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         complete_run();
      end
   end

   // -------------
   // Shared tasks
   // -------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ---------
   // Scenarios
   // ---------
   // Reset state, refused accesses and both internal timebases
   task automatic t_reset();
      check(32'(sp_oe), 32'h0);
      check(32'(cout), 32'h0);
      rd_reg(ics_pkg::REG_CTRL);
      check(v, 32'h0);
      wr_reg(ics_pkg::REG_COUNT, 32'h5);
      rd_reg(ics_pkg::REG_COUNT);
      check(v, 32'h0);
      rd_reg(4'hF);
      check(v, 32'h0);
      wr_reg(ics_pkg::REG_CTRL, EN);
      repeat (5000) @(posedge clock);
      rd_reg(ics_pkg::REG_COUNT);
      check(32'(v >= 32'h9 && v <= 32'hB), 32'h1);
      wr_reg(ics_pkg::REG_LOAD, 32'h0);
      wr_reg(ics_pkg::REG_CTRL, EN | 32'h1);
      repeat (500) @(posedge clock);
      rd_reg(ics_pkg::REG_COUNT);
      check(32'(v >= 32'hC6 && v <= 32'hCC), 32'h1);
   endtask

   // Rising edges of the chosen pin only, gate level and edge modes
   task automatic t_pin_gate();
      wr_reg(ics_pkg::REG_LOAD, 32'h0);
      wr_reg(ics_pkg::REG_CTRL, EN | 32'h2);
      i_fld.pulses(1'b0, 3);
      i_fld.pulses(1'b1, 1);
      rd_reg(ics_pkg::REG_COUNT);
      check(v, 32'h3);
      wr_reg(ics_pkg::REG_CTRL, EN | GEN | GLV | 32'h2);
      i_fld.pulses(1'b0, 2);
      rd_reg(ics_pkg::REG_COUNT);
      check(v, 32'h3);
      @(posedge clock) gate <= 1'b1;
      i_fld.pulses(1'b0, 2);
      rd_reg(ics_pkg::REG_COUNT);
      check(v, 32'h5);
      @(posedge clock) asel <= 1'b1;
      aux <= 1'b1;
      i_fld.pulses(1'b0, 1);
      rd_reg(ics_pkg::REG_COUNT);
      check(v, 32'h4);
      @(posedge clock) gate <= 1'b0;
      asel <= 1'b0;
      wr_reg(ics_pkg::REG_CTRL, EN | GEN | 32'h2);
      i_fld.pulses(1'b0, 1);
      rd_reg(ics_pkg::REG_COUNT);
      check(v, 32'h4);
      @(posedge clock) gate <= 1'b1;
      repeat (4) @(posedge clock);
      gate <= 1'b0;
      i_fld.pulses(1'b0, 2);
      rd_reg(ics_pkg::REG_COUNT);
      check(v, 32'h6);
   endtask

   // Falling edge, down count, export of the selected source
   task automatic t_fall_export();
      @(posedge clock) asel <= 1'b0;
      wr_reg(ics_pkg::REG_LOAD, 32'hA);
      wr_reg(ics_pkg::REG_CTRL, EN | FALL | DOWN | EXP | 32'h3);
      fork
         i_fld.pulses(1'b1, 1);
         begin
            repeat (20) @(posedge clock);
            #1 check(32'(sp_out), 32'h1);
            check(32'(sp_oe), 32'h1);
            rd_reg(ics_pkg::REG_COUNT);
            check(v, 32'hA);
            rd_reg(ics_pkg::REG_STATUS);
            check(v, 32'h4);
         end
      join
      rd_reg(ics_pkg::REG_COUNT);
      check(v, 32'h9);
      check(32'(sp_out), 32'h0);
   endtask

   // Roll over: terminal count, output pulse, sticky status, toggle
   task automatic t_roll();
      wr_reg(ics_pkg::REG_LOAD, 32'hFFFFFFFF);
      wr_reg(ics_pkg::REG_CTRL, EN | 32'h1);
      n = 0;
      m = 0;
      repeat (20) begin
         @(posedge clock);
         #1 if (tc === 1'b1) n++;
         if (cout === 1'b1) m++;
      end
      check(n, 32'h1);
      check(m, 32'h1);
      wr_reg(ics_pkg::REG_CTRL, 32'h0);
      rd_reg(ics_pkg::REG_STATUS);
      check(v & 32'h1, 32'h1);
      rd_reg(ics_pkg::REG_STATUS);
      check(v & 32'h1, 32'h0);
      wr_reg(ics_pkg::REG_LOAD, 32'hFFFFFFFF);
      wr_reg(ics_pkg::REG_CTRL, EN | TGL | 32'h1);
      repeat (20) @(posedge clock);
      #1 check(32'(cout), 32'h1);
      wr_reg(ics_pkg::REG_CTRL, 32'h0);
   endtask

   // Idle level choice and overcurrent off time with retries
   task automatic t_out();
      wr_reg(ics_pkg::REG_CTRL, IDLE);
      repeat (2) @(posedge clock);
      #1 check(32'(cout), 32'h1);
      wr_reg(ics_pkg::REG_CTRL, 32'h0);
      repeat (2) @(posedge clock);
      #1 check(32'(cout), 32'h0);
      @(posedge clock) oc <= 1'b1;
      @(posedge clock) oc <= 1'b0;
      n = 0;
      repeat (40) begin
         @(posedge clock);
         #1 if (cout === 1'b1) n++;
      end
      check(32'(n >= OFF - 1 && n <= OFF + 1), 32'h1);
      @(posedge clock) oc <= 1'b1;
      n = 0;
      repeat (100) begin
         @(posedge clock);
         #1 if (cout === 1'b1) n++;
      end
      check(32'(n >= 80), 32'h1);
      @(posedge clock) oc <= 1'b0;
      repeat (30) @(posedge clock);
      #1 check(32'(cout), 32'h0);
   endtask

   // Reset in mid run releases the export driver
   task automatic t_rst_again();
      wr_reg(ics_pkg::REG_CTRL, EN | EXP);
      repeat (2) @(posedge clock);
      #1 check(32'(sp_oe), 32'h1);
      @(posedge clock) reset <= 1'b1;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      #1 check(32'(sp_oe), 32'h0);
      check(32'(cout), 32'h0);
      rd_reg(ics_pkg::REG_CTRL);
      check(v, 32'h0);
   endtask

   // Main sequence
   initial begin
      reset = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      gate = 1'b0;
      aux = 1'b0;
      asel = 1'b0;
      oc = 1'b0;
      v = 32'h0;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      #1 t_reset();
      t_pin_gate();
      t_fall_export();
      t_roll();
      t_out();
      t_rst_again();
      complete_run();
   end
endmodule
`default_nettype wire

/* File: verilog/ics_counter.sv */
// Notes on behaviour
// - Slow 100 kHz and fast 20 MHz timebases offered as count sources.
// - Source from internal timebase or pin; gate and auxiliary from pins only; one output.
// - Source is edge detected; rising or falling edge selectable for pin sources.
// - Each active source edge counts up or down per configured direction.
// - Selected source may be driven out on the default source pin.
// - Source export driver stays released after reset until enabled.
// - Without external choice the source is an internal timebase.
// - Overcurrent turns output off 250 ms, retries, repeats while fault.
// - Idle output level low by default; software may set it high.
// - Count roll over yields a terminal-count event.
// - Gate works by edge or by level as configured.
`timescale 1ns/1ns
`default_nettype none
module ics_counter #(
   parameter int WIDTH = 32,
   parameter int FAULT_OFF = ics_pkg::FAULT_OFF_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_programmable_function_pin,
   input wire logic i_counter_zero_source_pin,
   input wire logic i_counter_gate_input,
   input wire logic i_aux_input,
   input wire logic i_aux_select,
   input wire logic i_overcurrent,
   output logic o_source_pin_out,
   output logic o_source_pin_oe,
   output logic o_counter_out,
   output logic o_terminal_count
);
   // Refuse sizes the logic cannot serve
   if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
      $error("WIDTH must be 2 to 32");
   end
   if (FAULT_OFF < 8) begin : g_bad_off
      $error("FAULT_OFF must be at least 8");
   end

   // ----------------------------------------
   // Registers and wires
   // ----------------------------------------
   logic [9:0] ctrl_q;
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   logic [31:0] rdata_q;
   logic [15:0] fast_acc_q;
   logic [15:0] slow_div_q;
   logic fast_en_q;
   logic slow_en_q;
   logic fast_tb_q;
   logic slow_tb_q;
   logic [31:0] off_cnt_q;
   logic fault_off_q;
   logic tc_q;
   logic out_q;
   logic toggle_q;
   logic exp_q;
   logic exp_oe_q;
   logic sticky_tc_q;
   logic pin_level;
   logic pin_rise;
   logic pin_fall;
   logic dflt_level;
   logic dflt_rise;
   logic dflt_fall;
   logic gate_level;
   logic gate_rise;
   logic aux_level;

   // Pin inputs through synchronisers
   ics_edge_sync u_pin (.i_clock(i_clock), .i_reset(i_reset),
      .i_async(i_programmable_function_pin), .o_level(pin_level),
      .o_rise(pin_rise), .o_fall(pin_fall));
   ics_edge_sync u_dflt (.i_clock(i_clock), .i_reset(i_reset),
      .i_async(i_counter_zero_source_pin), .o_level(dflt_level),
      .o_rise(dflt_rise), .o_fall(dflt_fall));
   ics_edge_sync u_gate (.i_clock(i_clock), .i_reset(i_reset),
      .i_async(i_counter_gate_input), .o_level(gate_level),
      .o_rise(gate_rise), .o_fall());
   ics_edge_sync u_aux (.i_clock(i_clock), .i_reset(i_reset),
      .i_async(i_aux_input), .o_level(aux_level),
      .o_rise(), .o_fall());

   // Control field decode
   wire [1:0] src_sel = ctrl_q[ics_pkg::CTRL_SRC_LSB +: 2];
   wire fall_sel = ctrl_q[ics_pkg::CTRL_FALL];
   wire down_cfg = ctrl_q[ics_pkg::CTRL_DOWN];
   wire export_en = ctrl_q[ics_pkg::CTRL_EXPORT];
   wire gate_lvl_mode = ctrl_q[ics_pkg::CTRL_GATE_LEVEL];
   wire gate_en = ctrl_q[ics_pkg::CTRL_GATE_EN];
   wire idle_high = ctrl_q[ics_pkg::CTRL_IDLE_HIGH];
   wire out_toggle = ctrl_q[ics_pkg::CTRL_OUT_TOGGLE];
   wire run_en = ctrl_q[ics_pkg::CTRL_ENABLE];

   // Timebase edges: each enable marks one rising timebase edge
   wire fast_wrap = ({1'b0, fast_acc_q} + {1'b0, ics_pkg::FAST_TB_STEP})
      >= {1'b0, ics_pkg::FAST_TB_MOD};
   wire slow_wrap = slow_div_q == 16'(ics_pkg::SLOW_TB_DIV - 1);

   // Source selection and edge choice
   wire src_rise = (src_sel == ics_pkg::ICS_SRC_SLOW) ? slow_en_q
      : (src_sel == ics_pkg::ICS_SRC_FAST) ? fast_en_q
      : (src_sel == ics_pkg::ICS_SRC_PIN) ? pin_rise : dflt_rise;
   wire src_fall = (src_sel == ics_pkg::ICS_SRC_PIN) ? pin_fall
      : (src_sel == ics_pkg::ICS_SRC_DEFAULT) ? dflt_fall
      : 1'b0;
   wire src_level = (src_sel == ics_pkg::ICS_SRC_SLOW) ? slow_tb_q
      : (src_sel == ics_pkg::ICS_SRC_FAST) ? fast_tb_q
      : (src_sel == ics_pkg::ICS_SRC_PIN) ? pin_level : dflt_level;
   // Internal timebases count on rising edge only
   wire src_int = ~src_sel[1];
   wire src_edge = (fall_sel & ~src_int) ? src_fall : src_rise;

   // Gate: level mode holds, edge mode arms on rising edge
   logic gate_armed_q;
   wire gate_ok = ~gate_en | (gate_lvl_mode ? gate_level
      : gate_armed_q);
   // Aux may steer direction instead of control bit
   wire count_down = i_aux_select ? aux_level : down_cfg;
   wire step = run_en & gate_ok & src_edge;
   wire rollover = step & (count_down ? (count_q == '0)
      : (count_q == {WIDTH{1'b1}}));

   // Register decode
   wire wr_ctrl = i_wr & (i_addr == ics_pkg::REG_CTRL);
   wire wr_load = i_wr & (i_addr == ics_pkg::REG_LOAD);
   wire [31:0] count_ext = 32'(count_q);
   wire [31:0] status_word = {27'h0000000, fault_off_q, gate_level,
      src_level, out_q, sticky_tc_q};
   wire [31:0] rd_mux = (i_addr == ics_pkg::REG_CTRL) ? {22'h000000, ctrl_q}
      : (i_addr == ics_pkg::REG_COUNT) ? count_ext
      : (i_addr == ics_pkg::REG_STATUS) ? status_word : 32'h00000000;

   // Next count
   always_comb begin
      count_d = count_q;
      if (wr_load) begin
         count_d = i_wdata[WIDTH-1:0];
      end else if (step) begin
         count_d = count_down ? count_q - 1'b1 : count_q + 1'b1;
      end
   end

   // ----------------------------------------
   // Timebase dividers
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         fast_acc_q <= 16'h0000;
         slow_div_q <= 16'h0000;
         fast_en_q <= 1'b0;
         slow_en_q <= 1'b0;
         fast_tb_q <= 1'b0;
         slow_tb_q <= 1'b0;
      end else begin
         fast_acc_q <= fast_wrap
            ? fast_acc_q + ics_pkg::FAST_TB_STEP - ics_pkg::FAST_TB_MOD
            : fast_acc_q + ics_pkg::FAST_TB_STEP;
         fast_en_q <= fast_wrap;
         fast_tb_q <= fast_wrap;
         slow_div_q <= slow_wrap ? 16'h0000 : slow_div_q + 16'h0001;
         slow_en_q <= slow_wrap;
         slow_tb_q <= slow_div_q < 16'(ics_pkg::SLOW_TB_DIV / 2);
      end
   end

   // ----------------------------------------
   // Control and counter
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         ctrl_q <= ics_pkg::CTRL_RESET;
         count_q <= '0;
         rdata_q <= 32'h00000000;
         gate_armed_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= i_wdata[9:0];
         end
         count_q <= count_d;
         rdata_q <= i_rd ? rd_mux : 32'h00000000;
         // A gate edge in the write cycle still arms
         if (gate_rise) begin
            gate_armed_q <= 1'b1;
         end else if (wr_ctrl) begin
            gate_armed_q <= 1'b0;
         end
      end
   end

   // Terminal count flag: set wins over read clear
   wire rd_status = i_rd & (i_addr == ics_pkg::REG_STATUS);
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         sticky_tc_q <= 1'b0;
         tc_q <= 1'b0;
      end else begin
         tc_q <= rollover;
         sticky_tc_q <= rollover | (sticky_tc_q & ~rd_status);
      end
   end

   // ----------------------------------------
   // Output switch with fault retry
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         off_cnt_q <= 32'h00000000;
         fault_off_q <= 1'b0;
      end else if (fault_off_q) begin
         if (off_cnt_q == 32'(FAULT_OFF - 1)) begin
            fault_off_q <= 1'b0;
            off_cnt_q <= 32'h00000000;
         end else begin
            off_cnt_q <= off_cnt_q + 32'h00000001;
         end
      end else if (i_overcurrent & ~out_q) begin
         fault_off_q <= 1'b1;
      end
   end

   // Pin level: low means switch on; high when released or faulted
   wire pulse_lvl = idle_high ^ rollover;
   wire next_lvl = out_toggle ? toggle_q ^ rollover : pulse_lvl;
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         toggle_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            toggle_q <= i_wdata[ics_pkg::CTRL_IDLE_HIGH];
         end else if (rollover) begin
            toggle_q <= ~toggle_q;
         end
         out_q <= (fault_off_q | (i_overcurrent & ~out_q)) ? 1'b1
            : next_lvl;
      end
   end

   // ----------------------------------------
   // Source export
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         exp_q <= 1'b0;
         exp_oe_q <= 1'b0;
      end else begin
         exp_q <= src_level;
         exp_oe_q <= export_en;
      end
   end

   assign o_rdata = rdata_q;
   assign o_source_pin_out = exp_q;
   assign o_source_pin_oe = exp_oe_q;
   assign o_counter_out = out_q;
   assign o_terminal_count = tc_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_export_after_reset: assert property (@(posedge i_clock)
      $fell(i_reset) |-> !o_source_pin_oe)
      else $error("export driven after reset");
   a_export_follow: assert property (@(posedge i_clock)
      disable iff (i_reset) export_en |=> o_source_pin_oe)
      else $error("export enable not followed");
   a_count_step: assert property (@(posedge i_clock)
      disable iff (i_reset) (step && !wr_load && !count_down)
      |=> count_q == $past(count_q) + 1'b1)
      else $error("up count wrong");
   a_count_hold: assert property (@(posedge i_clock)
      disable iff (i_reset) (!step && !wr_load) |=> $stable(count_q))
      else $error("count moved without edge");
   a_tc_on_roll: assert property (@(posedge i_clock)
      disable iff (i_reset) rollover |=> o_terminal_count)
      else $error("terminal count missing");
   a_fault_off: assert property (@(posedge i_clock)
      disable iff (i_reset) $rose(fault_off_q) |-> o_counter_out [*8])
      else $error("switch not off in fault");
   a_slow_rate: assert property (@(posedge i_clock)
      disable iff (i_reset) slow_en_q |=> !slow_en_q [*8])
      else $error("slow timebase too fast");
   a_gate_level: assert property (@(posedge i_clock)
      disable iff (i_reset) (gate_en && gate_lvl_mode && !gate_level)
      |-> !step)
      else $error("count while gate low");
   a_sync_delay: assert property (@(posedge i_clock)
      disable iff (i_reset) $rose(i_programmable_function_pin)
      ##1 i_programmable_function_pin |=> ##1 pin_level)
      else $error("pin not synchronised");
   a_idle_level: assert property (@(posedge i_clock)
      disable iff (i_reset) (!out_toggle && !rollover && !fault_off_q
      && !i_overcurrent) |=> o_counter_out == $past(idle_high))
      else $error("idle level wrong");
endmodule
`default_nettype wire

/* File: verilog/ics_edge_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser with edge detect on the settled stage
module ics_edge_sync (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_async,
   output logic o_level,
   output logic o_rise,
   output logic o_fall
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // ----------------------------------------
   // Synchroniser stages
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Edges seen only on settled stages
   assign o_level = sync_q;
   assign o_rise = sync_q & ~last_q;
   assign o_fall = ~sync_q & last_q;
endmodule
`default_nettype wire

/* File: verilog/ics_pkg.sv */
package ics_pkg;
   // Clock and timebases
   localparam int CLOCK_HZ = 50000000;
   localparam int FAST_TB_HZ = 20000000;
   localparam int SLOW_TB_HZ = 100000;
   // Fast timebase enable: phase step of a fractional divider
   localparam logic [15:0] FAST_TB_STEP = 16'(FAST_TB_HZ / 1000);
   localparam logic [15:0] FAST_TB_MOD = 16'(CLOCK_HZ / 1000);
   localparam int SLOW_TB_DIV = CLOCK_HZ / SLOW_TB_HZ;
   // Overcurrent off time
   localparam int FAULT_OFF_MS = 250;
   localparam int FAULT_OFF_CYCLES = (CLOCK_HZ / 1000) * FAULT_OFF_MS;
   // Least external source high width and period
   localparam int SRC_PW_NS = 1000;
   localparam int SRC_PER_NS = 2000;
   localparam int CLK_NS = 20;
   localparam int SRC_PW_CYCLES = (SRC_PW_NS + CLK_NS - 1) / CLK_NS;
   localparam int SRC_PER_CYCLES = (SRC_PER_NS + CLK_NS - 1) / CLK_NS;
   // Source selection codes
   typedef enum logic [1:0] {
      ICS_SRC_SLOW = 2'b00,
      ICS_SRC_FAST = 2'b01,
      ICS_SRC_PIN = 2'b10,
      ICS_SRC_DEFAULT = 2'b11
   } ics_src_type;
   // Register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_COUNT = 4'h1;
   localparam logic [3:0] REG_LOAD = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   // Control field positions
   localparam int CTRL_SRC_LSB = 0;
   localparam int CTRL_FALL = 2;
   localparam int CTRL_DOWN = 3;
   localparam int CTRL_EXPORT = 4;
   localparam int CTRL_GATE_LEVEL = 5;
   localparam int CTRL_GATE_EN = 6;
   localparam int CTRL_IDLE_HIGH = 7;
   localparam int CTRL_OUT_TOGGLE = 8;
   localparam int CTRL_ENABLE = 9;
   localparam logic [9:0] CTRL_RESET = 10'h000;
endpackage
